// ---- hdl/itc_regs.svh ----
`ifndef ITC_REGS_SVH
`define ITC_REGS_SVH
// ==========================================================
// status longword width, trace bit positions and reset values
`define ITC_PSL_W        32
`define ITC_PSL_T_BIT    4
`define ITC_PSL_TP_BIT   30
`define ITC_PSL_RST      32'h0000_0000
`define ITC_PC_RST       32'h0000_0000
`endif

// ---- hdl/itc_pkg.sv ----
`default_nettype none
`include "itc_regs.svh"
package itc_pkg;
   // ==========================================================
   // event kinds presented by the sequencer
   typedef enum logic [3:0] {
      ITC_EV_NONE     = 4'h0,
      ITC_EV_INSTR    = 4'h1, // ordinary instruction completes
      ITC_EV_FAULT    = 4'h2, // fault or mid-instruction interrupt
      ITC_EV_ABORT    = 4'h3, // abort or arithmetic trap
      ITC_EV_INTR_END = 4'h4, // interrupt between instructions
      ITC_EV_CHM      = 4'h5,
      ITC_EV_REI      = 4'h6,
      ITC_EV_BIS      = 4'h7,
      ITC_EV_CALL     = 4'h8
   } itc_event_t;

   typedef struct packed {
      itc_event_t                  kind;
      logic [`ITC_PSL_W-1:0]       new_psl;  // psl to install (bis, chm, rei)
      logic [31:0]                 pc;       // start pc of current instruction
      logic [31:0]                 next_pc;  // pc of next instruction
   } itc_req_t;

   typedef struct packed {
      logic                        valid;
      logic                        trace;    // trace fault taken at boundary
      logic                        save;     // status longword image pushed
      logic [`ITC_PSL_W-1:0]       psl_img;
      logic [31:0]                 pc_img;
   } itc_rsp_t;

   typedef enum logic [1:0] {
      ITC_ST_IDLE  = 2'b00,
      ITC_ST_CHECK = 2'b01,
      ITC_ST_EXEC  = 2'b10
   } itc_state_t;
endpackage : itc_pkg
`default_nettype wire

// ---- hdl/itc_trace_ctrl.sv ----
// Notes on behaviour
// RL1 - exactly one trace exception before each traced instruction, whatever else happens.
// RL2 - trace saves the pc of the instruction that would execute next.
// RL3 - trace with memory fault or odd fetch abort may be taken either order.
// RL4 - an instruction's trace fault beats all its other exceptions.
// RL5 - status longword has separate trace enable and pending bits; pending raises exception.
// RL6 - set pending bit faults at next instruction start before any processing.
// RL7 - at instruction start, pending set means clear it then take trace.
// RL8 - after the start check, load pending from enable.
// RL9 - fault or mid interrupt: clear pending, save start pc, recheck at start.
// RL10 - abort or arithmetic trap leaves pending unchanged in saved longword.
// RL11 - interrupt after completion, before next check, leaves pending unchanged.
// RL12 - change mode clears both bits; saved image shows both set if enabled.
// RL13 - after return, pending set if enable was set or restored pending set.
// RL14 - status bit set enabling trace traces from second following instruction.
// RL15 - call_with_stack_args_instr save image with enable clear; live enable unchanged.
// RL16 - reserved instruction detection follows the trace check.
// RL17 - exception detected during execution clears pending before initiation.
// RL18 - every initiation saves whole status longword including both trace bits.
`default_nettype none
`include "itc_regs.svh"
module itc_trace_ctrl (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              start,        // next instruction boundary reached
   input  wire logic              req_valid,
   input  wire itc_pkg::itc_req_t req,
   input  wire logic              mm_fault,     // memory fault pending at start
   output logic                   busy,
   output logic                   decode_ok,    // reserved check may proceed
   output itc_pkg::itc_rsp_t      rsp,
   output logic [`ITC_PSL_W-1:0]  processor_status_longword
);
   import itc_pkg::*;

   // ==========================================================
   // state
   itc_state_t             state_q;
   logic [`ITC_PSL_W-1:0]  psl_q;
   logic [31:0]            pc_q;
   itc_rsp_t               rsp_q;
   logic                   dec_q;
   logic                   busy_q;

   wire logic t_bit  = psl_q[`ITC_PSL_T_BIT];
   wire logic tp_bit = psl_q[`ITC_PSL_TP_BIT];

   function automatic logic [`ITC_PSL_W-1:0] set_tp(input logic [`ITC_PSL_W-1:0] p, input logic v);
      logic [`ITC_PSL_W-1:0] r;
      r = p;
      r[`ITC_PSL_TP_BIT] = v;
      return r;
   endfunction : set_tp

   // ==========================================================
   // boundary sequencing
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ITC_ST_IDLE;
      end else begin
         case (state_q)
            ITC_ST_IDLE:  if (start) state_q <= ITC_ST_CHECK;
            ITC_ST_CHECK: if (!tp_bit) state_q <= ITC_ST_EXEC;   // [RL6]
            ITC_ST_EXEC:  if (req_valid) state_q <= ITC_ST_IDLE;
            default:      state_q <= ITC_ST_IDLE;
         endcase
      end
   end

   // busy flag registered alongside the state so the output comes from a flop
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_q <= 1'b0;
      end else if (state_q == ITC_ST_IDLE && start) begin
         busy_q <= 1'b1;
      end else if (state_q == ITC_ST_EXEC && req_valid) begin
         busy_q <= 1'b0;
      end
   end

   // ==========================================================
   // status longword and trace bits
   always_ff @(posedge clk) begin
      if (rst) begin
         psl_q <= `ITC_PSL_RST;
         pc_q  <= `ITC_PC_RST;
      end else begin
         case (state_q)
            ITC_ST_CHECK: begin
               if (tp_bit)
                  psl_q <= set_tp(psl_q, 1'b0);                  // [RL7] [RL1]
               else
                  psl_q <= set_tp(psl_q, t_bit);                 // [RL8] [RL5]
            end
            ITC_ST_EXEC: if (req_valid) begin
               // a faulted instruction restarts, otherwise the next one runs
               pc_q <= (req.kind == ITC_EV_FAULT) ? req.pc : req.next_pc; // [RL2]
               case (req.kind)
                  ITC_EV_FAULT: psl_q <= set_tp(psl_q, 1'b0);    // [RL9] [RL17]
                  ITC_EV_CHM: begin
                     psl_q <= req.new_psl;
                     psl_q[`ITC_PSL_T_BIT]  <= 1'b0;             // [RL12]
                     psl_q[`ITC_PSL_TP_BIT] <= 1'b0;
                  end
                  ITC_EV_REI:
                     psl_q <= set_tp(req.new_psl,
                                     t_bit | req.new_psl[`ITC_PSL_TP_BIT]); // [RL13]
                  ITC_EV_BIS:
                     psl_q <= set_tp(req.new_psl, tp_bit);       // [RL14]
                  default: psl_q <= psl_q;                       // [RL10] [RL11] [RL15]
               endcase
            end
            default: psl_q <= psl_q;
         endcase
      end
   end

   // ==========================================================
   // response: trace fault and stack images
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp_q <= '0;
         dec_q <= 1'b0;
      end else begin
         rsp_q <= '0;
         dec_q <= 1'b0;
         if (state_q == ITC_ST_CHECK) begin
            if (tp_bit) begin
               // trace wins; a simultaneous memory fault waits its turn
               rsp_q.valid   <= 1'b1;                            // [RL4] [RL3]
               rsp_q.trace   <= 1'b1;
               rsp_q.save    <= 1'b1;
               rsp_q.psl_img <= set_tp(psl_q, 1'b0);
               rsp_q.pc_img  <= pc_q;                            // [RL2]
            end else begin
               dec_q <= ~mm_fault;                               // [RL16]
            end
         end else if (state_q == ITC_ST_EXEC && req_valid) begin
            rsp_q.valid  <= 1'b1;
            rsp_q.pc_img <= req.next_pc;
            case (req.kind)
               ITC_EV_FAULT: begin
                  rsp_q.save    <= 1'b1;
                  rsp_q.psl_img <= set_tp(psl_q, 1'b0);          // [RL9] [RL18]
                  rsp_q.pc_img  <= req.pc;
               end
               ITC_EV_ABORT, ITC_EV_INTR_END: begin
                  rsp_q.save    <= 1'b1;
                  rsp_q.psl_img <= psl_q;                        // [RL10] [RL11] [RL18]
               end
               ITC_EV_CHM: begin
                  rsp_q.save    <= 1'b1;
                  rsp_q.psl_img <= t_bit ? (psl_q | (`ITC_PSL_W'(1) << `ITC_PSL_T_BIT)
                                                  | (`ITC_PSL_W'(1) << `ITC_PSL_TP_BIT))
                                         : psl_q;                // [RL12]
               end
               ITC_EV_CALL: begin
                  rsp_q.save    <= 1'b1;
                  rsp_q.psl_img <= psl_q & ~(`ITC_PSL_W'(1) << `ITC_PSL_T_BIT); // [RL15]
               end
               default: rsp_q.save <= 1'b0;
            endcase
         end
      end
   end

   assign busy      = busy_q;
   assign decode_ok = dec_q;
   assign rsp       = rsp_q;
   assign processor_status_longword       = psl_q;
endmodule : itc_trace_ctrl
`default_nettype wire

// ---- testbench/itc_trace_ctrl_monitor.sv ----
`default_nettype none
`include "itc_regs.svh"
module itc_trace_ctrl_monitor (
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  start,
   input wire logic                  req_valid,
   input wire itc_pkg::itc_req_t     req,
   input wire logic                  mm_fault,
   input wire logic                  busy,
   input wire logic                  decode_ok,
   input wire itc_pkg::itc_rsp_t     rsp,
   input wire logic [`ITC_PSL_W-1:0] processor_status_longword
);
   import itc_pkg::*;
   localparam int TB = `ITC_PSL_T_BIT;
   localparam int PB = `ITC_PSL_TP_BIT;
   wire logic tk = req_valid && busy;
   // ==========================================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_excl; !(rsp.trace && decode_ok);
   endproperty
   a_excl: assert property (p_excl) else $error("trace and decode together");
   property p_trace; rsp.trace |-> !processor_status_longword[PB] && busy;
   endproperty
   a_trace: assert property (p_trace) else $error("pending not cleared on trace");
   property p_load; decode_ok |-> processor_status_longword[PB] == processor_status_longword[TB];
   endproperty
   a_load: assert property (p_load) else $error("pending not loaded from enable");
   property p_fault; tk && req.kind == ITC_EV_FAULT |=> rsp.valid && !rsp.psl_img[PB] && !processor_status_longword[PB]
      && rsp.pc_img == $past(req.pc);
   endproperty
   a_fault: assert property (p_fault) else $error("fault image wrong");
   property p_abort; tk && (req.kind == ITC_EV_ABORT || req.kind == ITC_EV_INTR_END) |=> rsp.save
      && rsp.psl_img[PB] == $past(processor_status_longword[PB]) && rsp.psl_img[TB] == $past(processor_status_longword[TB]);
   endproperty
   a_abort: assert property (p_abort) else $error("abort image wrong");
   property p_chm; tk && req.kind == ITC_EV_CHM |=> !processor_status_longword[TB] && !processor_status_longword[PB] && rsp.psl_img[PB] == $past(processor_status_longword[TB]);
   endproperty
   a_chm: assert property (p_chm) else $error("change mode bits wrong");
   property p_rei; tk && req.kind == ITC_EV_REI |=> processor_status_longword[PB] == ($past(processor_status_longword[TB]) || $past(req.new_psl[PB]));
   endproperty
   a_rei: assert property (p_rei) else $error("return pending wrong");
   property p_bis; tk && req.kind == ITC_EV_BIS |=> processor_status_longword[PB] == $past(processor_status_longword[PB]);
   endproperty
   a_bis: assert property (p_bis) else $error("bit set changed pending");
   property p_call; tk && req.kind == ITC_EV_CALL |=> rsp.save && !rsp.psl_img[TB] && processor_status_longword[TB] == $past(processor_status_longword[TB]);
   endproperty
   a_call: assert property (p_call) else $error("call image wrong");
endmodule : itc_trace_ctrl_monitor
bind itc_trace_ctrl itc_trace_ctrl_monitor u_mon (.clk(clk), .rst(rst), .start(start), .req_valid(req_valid),
   .req(req), .mm_fault(mm_fault), .busy(busy), .decode_ok(decode_ok), .rsp(rsp), .processor_status_longword(processor_status_longword));
`default_nettype wire

// ---- testbench/itc_trace_ctrl_test.sv ----
`default_nettype none
`include "itc_regs.svh"
module itc_trace_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import itc_pkg::*;
   localparam int TB = `ITC_PSL_T_BIT;
   localparam int PB = `ITC_PSL_TP_BIT;
   logic clk = 0, rst = 1, start = 0, req_valid = 0, mm_fault = 0, busy, decode_ok;
   logic t = 0, tp = 0, it, ip;
   itc_req_t req = '0;
   itc_rsp_t rsp;
   logic [`ITC_PSL_W-1:0] processor_status_longword;
   logic [31:0] lfsr = 32'h3bb73ffa, last_pc = 32'h0, np;
   logic [3:0] k;
   int errors = 0, tests_run = 0;
   itc_trace_ctrl dut (.clk(clk), .rst(rst), .start(start), .req_valid(req_valid), .req(req),
      .mm_fault(mm_fault), .busy(busy), .decode_ok(decode_ok), .rsp(rsp), .processor_status_longword(processor_status_longword));
   initial forever #2.5 clk = ~clk;
   // ==========================================================
   // helpers
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict
   task automatic wait_ans();
      int n;
      n = 0;
      do begin @(posedge clk); #1; n++; end while (!(rsp.trace || rsp.valid || decode_ok) && n < 20);
      if (n >= 20) check(32'h1, 32'h0);
   endtask : wait_ans
   initial begin
      #100000;
      check(32'h1, 32'h0);
      give_verdict();
   end
   // ==========================================================
   // random instruction stream against bench model
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 0;
      repeat (300) begin
         lfsr = nxt(lfsr);
         np = nxt(lfsr);
         k = 4'(lfsr[2:0]) + 4'h1;
         @(negedge clk);
         start = 1;
         mm_fault = lfsr[9] & tp;
         wait_ans();
         @(negedge clk);
         start = 0;
         mm_fault = 0;
         check(rsp.trace, tp);
         if (tp) begin
            check(rsp.pc_img, last_pc);
            tp = 0;
            wait_ans();
            @(negedge clk);
         end
         check(decode_ok, 1'h1);
         check(busy, 1'h1);
         tp = t;
         check(processor_status_longword[PB], tp);
         req_valid = 1;
         req = '{kind: itc_event_t'(k), new_psl: np, pc: np ^ lfsr, next_pc: (np ^ lfsr) + 32'h4};
         wait_ans();
         it = (k == 4'h8) ? 1'h0 : t;
         ip = (k == 4'h2) ? 1'h0 : tp;
         if (k == 4'h2 || k == 4'h5) tp = 0;
         if (k == 4'h6) tp = t | np[PB];
         if (k == 4'h5) t = 0;
         if (k == 4'h6 || k == 4'h7) t = np[TB];
         check(rsp.valid, 1'h1);
         check(rsp.save, k inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h8});
         if (rsp.save === 1'h1) check({rsp.psl_img[TB], rsp.psl_img[PB]}, {it, ip});
         if (k == 4'h2) check(rsp.pc_img, req.pc);
         last_pc = (k == 4'h2) ? req.pc : req.next_pc;
         @(negedge clk);
         req_valid = 0;
         check(busy, 1'h0);
         check({processor_status_longword[TB], processor_status_longword[PB]}, {t, tp});
      end
      give_verdict();
   end
endmodule : itc_trace_ctrl_test
`default_nettype wire
